// >>> inc/asc_defines.svh
// Timing figures and pin layout constants for the async SRAM host controller.
// Assumes a 100 MHz clock; every count derives from a time and the period.
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
// Clock period in picoseconds
`define ASC_CLK_PS         10000
// Power-up wait in microseconds and derived cycles
`define ASC_POWERUP_US     100
`define ASC_POWERUP_CYC    ((`ASC_POWERUP_US * 1000000 + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
// Slowest grade figures in ns, min times rounded up to cycles
`define ASC_ADDR_ACCESS_NS 15
`define ASC_SEL_WEND_NS    10
`define ASC_WDATA_SETUP_NS 8
`define ASC_LANE_WEND_NS   9
`define ASC_RELEASE_NS     7
`define ASC_CYC(ns)        (((ns) * 1000 + `ASC_CLK_PS - 1) / `ASC_CLK_PS)
// Read wait: address access plus one cycle for input capture
`define ASC_RD_CYC         (`ASC_CYC(`ASC_ADDR_ACCESS_NS) + 1)
// Write strobe low time covers every write-end minimum
`define ASC_WR_CYC         `ASC_CYC(`ASC_SEL_WEND_NS)
// Bus turnaround after a read before a write may drive
`define ASC_TURN_CYC       `ASC_CYC(`ASC_RELEASE_NS)
// Lane layout
`define ASC_LANE_W         8
`endif

// >>> inc/asc_pkg.sv
// Types for the async SRAM host controller.
// Assumes asc_defines.svh for all numeric figures.
`default_nettype none
package asc_pkg;
   // Controller sequence states
   typedef enum logic [2:0] {
      ASC_POWERUP,
      ASC_IDLE,
      ASC_READ,
      ASC_WRITE,
      ASC_WEND,
      ASC_TURN
   } asc_state_e;
endpackage
`default_nettype wire

// >>> inc/asc_sync_if.sv
// Carrier between the pin synchroniser and the controller core.
// Assumes both ends on the one system clock.
`default_nettype none
interface asc_sync_if #(parameter int W = 16);
   logic [W-1:0] raw;   // Pin level as it arrives
   logic [W-1:0] clean; // Level after three stages, settled
   modport src (input raw, output clean);
   modport dst (output raw, input clean);
endinterface
`default_nettype wire

// >>> sim/asc_ctrl_properties.sv
// Pin-timing checks on the SRAM host controller top.
// Assumes one clock and synchronous active-high reset.
`default_nettype none
module asc_ctrl_properties #(
   parameter int AW         = 16,
   parameter int POWERUP_CY = 20
) (
   input wire logic          clock,
   input wire logic          rst,
   input wire logic          req_ready,
   input wire logic          rsp_valid,
   input wire logic [AW-1:0] mem_addr,
   input wire logic          mem_sel_n,
   input wire logic          mem_oe_n,
   input wire logic          mem_we_n,
   input wire logic          lower_lane_sel_n,
   input wire logic          upper_lane_sel_n,
   input wire logic [15:0]   mem_data_o,
   input wire logic [1:0]    mem_data_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic [15:0] up_cnt_reg; // Cycles since release, saturating
   // Saturate so long runs never wrap
   always_ff @(posedge clock) begin
      up_cnt_reg <= rst ? 16'h0000 : up_cnt_reg + {15'h0000, up_cnt_reg != 16'hFFFF};
   end
   // Write window open on the pins
   sequence s_wr_open;
      !mem_we_n && !mem_sel_n;
   endsequence
   // Read window open on the pins
   sequence s_rd_open;
      !mem_sel_n && !mem_oe_n && mem_we_n;
   endsequence
   a_power_wait: assert property (
      (req_ready || !mem_sel_n) |-> up_cnt_reg >= 16'(POWERUP_CY)) else $error("early access");
   a_write_select: assert property (
      !mem_we_n |-> !mem_sel_n) else $error("strobe without select");
   a_end_hold: assert property (
      s_wr_open ##1 mem_we_n |-> $stable(mem_addr) && $stable(mem_data_o)) else $error("hold");
   a_lane_drive: assert property (
      s_wr_open |-> mem_data_oe == ~{upper_lane_sel_n, lower_lane_sel_n}) else $error("lanes");
   a_end_together: assert property (
      $rose(mem_we_n) |-> $rose(mem_sel_n)) else $error("split write end");
   a_addr_steady: assert property (
      !mem_sel_n ##1 !mem_sel_n |-> $stable(mem_addr)) else $error("address moved");
   a_read_span: assert property (
      $fell(mem_oe_n) |-> s_rd_open[*6] ##1 (rsp_valid && mem_oe_n)) else $error("read span");
   a_read_float: assert property (
      !mem_oe_n || !$past(mem_oe_n) |-> mem_data_oe == 2'h0) else $error("drive in read");
endmodule
`default_nettype wire

// >>> sim/asc_ctrl_tb_top.sv
// Self-checking bench: controller against a behavioural SRAM.
// Assumes 100 MHz clock and a power-up wait shortened to 20 cycles.
`default_nettype none
module asc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PU = 20; // Shortened power-up wait
   logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0, slow = 1'b0;
   logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, flt = 16'h5A5A;
   logic [1:0]  req_lane_n = 2'h3;
   wire logic req_ready, rsp_valid, mem_sel_n, mem_oe_n, mem_we_n;
   wire logic lower_lane_sel_n, upper_lane_sel_n;
   wire logic [15:0] rsp_rdata, mem_addr, mem_data_i, mem_data_o, ram_o;
   wire logic [1:0]  mem_data_oe, ram_oe;
   int checked = 0, failures = 0, cyc = 0;
   always #5 clock = ~clock;
   // Floating lanes show a pattern that changes every cycle
   always @(posedge clock) flt <= ~flt;
   for (genvar k = 0; k < 2; k++) begin : g_lane
      assign mem_data_i[8*k+:8] = mem_data_oe[k] ? mem_data_o[8*k+:8] :
                                  ram_oe[k] ? ram_o[8*k+:8] : flt[8*k+:8];
   end
   asc_ctrl #(.AW(16), .POWERUP_CY(PU)) asc_ctrl_i (.clock, .rst, .req_valid, .req_write,
      .req_addr, .req_wdata, .req_lane_n, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr,
      .mem_sel_n, .mem_oe_n, .mem_we_n, .lower_lane_sel_n, .upper_lane_sel_n, .mem_data_i,
      .mem_data_o, .mem_data_oe);
   asc_sram_model asc_sram_model_i (.slow, .addr(mem_addr), .sel_n(mem_sel_n),
      .oe_n(mem_oe_n), .we_n(mem_we_n), .lane_n({upper_lane_sel_n, lower_lane_sel_n}),
      .dq_i(mem_data_i), .dq_o(ram_o), .dq_oe(ram_oe));
   task automatic summarize();
      $display("checked=%0d failures=%0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One request; bounded waits for ready and read data
   task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                      input logic [1:0] ln, output logic [15:0] q);
      int n;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin @(posedge clock); #1; n++; end
      {req_valid, req_write, req_addr, req_wdata, req_lane_n} = {1'b1, w, a, d, ln};
      @(posedge clock); #1;
      req_valid = 1'b0;
      n = 0;
      while (!w && rsp_valid !== 1'b1 && n < 20) begin @(posedge clock); #1; n++; end
      q = rsp_rdata;
      if (!w) chk({15'h0000, rsp_valid}, 16'h0001);
      while (req_ready !== 1'b1 && n < 40) begin @(posedge clock); #1; n++; end
      chk({15'h0000, req_ready}, 16'h0001);
   endtask
   // Reset, then no select until the power-up wait is over
   task automatic t_power();
      int n;
      n = 0;
      rst = 1'b1;
      repeat (20) @(posedge clock);
      #1 rst = 1'b0;
      while (req_ready !== 1'b1 && n < 200) begin
         chk({15'h0000, mem_sel_n}, 16'h0001);
         @(posedge clock); #1; n++;
      end
      chk({15'h0000, n >= PU && req_ready === 1'b1}, 16'h0001);
   endtask
   // Every lane code on writes and reads
   task automatic t_lanes();
      logic [15:0] q, e, a;
      for (int i = 0; i < 4; i++) begin
         a = 16'h0100 + 16'(i);
         acc(1'b1, a, 16'hA5C3, 2'h0, q);
         acc(1'b1, a, 16'h5A3C, 2'(i), q);
         e = {i[1] ? 8'hA5 : 8'h5A, i[0] ? 8'hC3 : 8'h3C};
         chk(asc_sram_model_i.mem[a], e);
         acc(1'b0, a, 16'h0000, 2'(i), q);
         chk(q, e & {{8{!i[1]}}, {8{!i[0]}}});
      end
   endtask
   // Slow device, boundary addresses, write straight after read
   task automatic t_slow();
      logic [15:0] q;
      slow = 1'b1;
      acc(1'b1, 16'hFFFF, 16'hBEEF, 2'h0, q);
      acc(1'b1, 16'h0000, 16'h1357, 2'h0, q);
      acc(1'b0, 16'hFFFF, 16'h0000, 2'h0, q);
      chk(q, 16'hBEEF);
      acc(1'b0, 16'h0000, 16'h0000, 2'h0, q);
      chk(q, 16'h1357);
      acc(1'b1, 16'hFFFF, 16'h2468, 2'h0, q);
      chk(asc_sram_model_i.mem[16'hFFFF], 16'h2468);
      slow = 1'b0;
   endtask
   // Hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      logic [15:0] q;
      t_power();
      t_lanes();
      t_slow();
      t_power();
      acc(1'b0, 16'hFFFF, 16'h0000, 2'h0, q);
      chk(q, 16'h2468);
      summarize();
   end
endmodule
bind asc_ctrl asc_ctrl_properties #(.AW(AW), .POWERUP_CY(POWERUP_CY)) asc_ctrl_properties_i (
   .clock, .rst, .req_ready, .rsp_valid, .mem_addr, .mem_sel_n, .mem_oe_n, .mem_we_n,
   .lower_lane_sel_n, .upper_lane_sel_n, .mem_data_o, .mem_data_oe);
`default_nettype wire

// >>> sim/asc_sram_model.sv
// Behavioural 16-bit asynchronous SRAM with two byte lanes.
// Assumes the bench resolves the shared data pins.
`default_nettype none
module asc_sram_model (
   input  wire logic        slow,
   input  wire logic [15:0] addr,
   input  wire logic        sel_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [1:0]  lane_n,
   input  wire logic [15:0] dq_i,
   output logic [15:0]      dq_o,
   output logic [1:0]       dq_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [0:65535]; // Storage array
   logic [1:0]  wr_end;        // High when a lane's write window is shut
   // Deselect powers down and drives nothing
   wire rd = !sel_n && !oe_n && we_n;
   // Old word for 3 ns, garbage until the access delay runs out
   always @(addr or rd) begin
      dq_o <= #3 ~dq_o;
      dq_o <= #(slow ? 15 : 8) mem[addr];
   end
   // Drive at once, release late
   assign #(0, 7) dq_oe[0] = rd && !lane_n[0];
   assign #(0, 7) dq_oe[1] = rd && !lane_n[1];
   assign wr_end = {sel_n | we_n | lane_n[1], sel_n | we_n | lane_n[0]};
   // Data taken at the edge that shuts the window
   always @(posedge wr_end[0]) mem[addr][7:0] = dq_i[7:0];
   always @(posedge wr_end[1]) mem[addr][15:8] = dq_i[15:8];
endmodule
`default_nettype wire

// >>> src/asc_ctrl.sv
// Host controller for an asynchronous 16-bit SRAM with byte lanes.
// Assumes one 100 MHz clock, synchronous reset, and the SRAM on raw pins.
// Behaviour
// RL1 - Wait 100 us before the first access
// RL2 - Sample read data after address access delay
// RL3 - Old data held briefly after address change
// RL4 - Select access delay covered by read wait
// RL5 - Output enable access covered by read wait
// RL6 - Lane access covered by read wait
// RL7 - Turnaround before driving after a read
// RL8 - Deselect between accesses for standby
// RL9 - Address and select held before write end
// RL10 - Address valid at write start
// RL11 - Address and data held through write end
// RL12 - Write data set up before write end
// RL13 - Lane enables held before write end
// RL14 - Write is overlap of select, strobe, lane
// RL15 - Strobe edge terminates, hold measured there
// RL16 - Select and strobe rise together safely
// RL17 - Lanes float when enables are high
// RL18 - Read: select, output enable low, strobe high
// RL19 - Write: only enabled lanes take data
// RL20 - No lane enable means no data drive
// RL21 - Address before select falls on reads; code launches both on the same edge
// RL22 - Round minimum intervals up to cycles
`include "asc_defines.svh"
`default_nettype none
module asc_ctrl #(
   parameter int AW         = 16,
   parameter int POWERUP_CY = `ASC_POWERUP_CYC
) (
   input  wire logic          clock,
   input  wire logic          rst,
   // User request side
   input  wire logic          req_valid,
   input  wire logic          req_write,
   input  wire logic [AW-1:0] req_addr,
   input  wire logic [15:0]   req_wdata,
   input  wire logic [1:0]    req_lane_n,
   output logic               req_ready,
   output logic               rsp_valid,
   output logic [15:0]        rsp_rdata,
   // Memory pins
   output logic [AW-1:0]      mem_addr,
   output logic               mem_sel_n,
   output logic               mem_oe_n,
   output logic               mem_we_n,
   output logic               lower_lane_sel_n,
   output logic               upper_lane_sel_n,
   input  wire logic [15:0]   mem_data_i,
   output logic [15:0]        mem_data_o,
   output logic [1:0]         mem_data_oe
);
   // Counter width covers the power-up count
   // Read, write and turnaround counts are far below the power-up count
   localparam int CW = $clog2(POWERUP_CY + 1);

   // All controller state in one packed struct
   typedef struct packed {
      asc_pkg::asc_state_e state;
      logic [CW-1:0]       cnt;
      logic                ready;
      logic                rvalid;
      logic [15:0]         rdata;
      logic [AW-1:0]       addr;
      logic                sel_n;
      logic                oe_n;
      logic                we_n;
      logic [1:0]          lane_n;
      logic [15:0]         dout;
      logic [1:0]          doe;
   } asc_ctrl_s;

   asc_ctrl_s st_reg;  // Registered state
   asc_ctrl_s st_next; // Next state

   // Synchronised read data from the pins
   asc_sync_if #(.W(16)) rd_if ();
   assign rd_if.raw = mem_data_i;

   // Pin levels are asynchronous to clock, hence the three stages
   // Read data passes three stages; the read wait includes them
   asc_sync #(
      .W (16)
   ) u_sync (
      .clock (clock),
      .rst   (rst),
      .sif   (rd_if)
   );

   // Cycle count as counter width
   function automatic logic [CW-1:0] cyc(input int n);
      return CW'(n);
   endfunction

   // Sequencer
   always_comb begin
      st_next        = st_reg;
      st_next.rvalid = 1'b0;
      case (st_reg.state)
         asc_pkg::ASC_POWERUP: begin
            // No access until the supply wait has elapsed
            // Pins stay idle meanwhile; only the counter moves
            if (st_reg.cnt == cyc(POWERUP_CY - 1)) begin // RL1
               st_next.state = asc_pkg::ASC_IDLE;
               st_next.ready = 1'b1;
               st_next.cnt   = '0;
            end else begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end
         end
         asc_pkg::ASC_IDLE: begin
            // Deselected here: memory drops into standby
            st_next.sel_n  = 1'b1; // RL8
            st_next.oe_n   = 1'b1;
            st_next.we_n   = 1'b1;
            st_next.lane_n = 2'h3;
            st_next.doe    = 2'h0;
            if (req_valid && st_reg.ready) begin
               st_next.ready = 1'b0;
               st_next.cnt   = '0;
               // Address, select and lanes launched in the same edge
               st_next.addr   = req_addr; // RL10 RL21
               st_next.sel_n  = 1'b0;
               st_next.lane_n = req_lane_n;
               if (req_write) begin
                  // Strobe low with data; only enabled lanes driven
                  st_next.state = asc_pkg::ASC_WRITE;
                  st_next.we_n  = 1'b0; // RL14
                  st_next.dout  = req_wdata;
                  st_next.doe   = ~req_lane_n; // RL19 RL20
               end else begin
                  st_next.state = asc_pkg::ASC_READ;
                  st_next.oe_n  = 1'b0; // RL18
               end
            end
         end
         asc_pkg::ASC_READ: begin
            // Wait the full address access time plus capture stages
            // Limitation: always paced for the slowest grade; fast parts idle
            if (st_reg.cnt == cyc(`ASC_RD_CYC + 2)) begin // RL2 RL4 RL5 RL6 RL22
               // Disabled lanes are floating; mask them to zero
               st_next.rdata = {rd_if.clean[15:8] & {8{~st_reg.lane_n[1]}},
                                rd_if.clean[7:0] & {8{~st_reg.lane_n[0]}}}; // RL17
               // Enables rise with select; the memory lets go 7 ns later, inside the turnaround
               st_next.rvalid = 1'b1;
               st_next.sel_n  = 1'b1;
               st_next.oe_n   = 1'b1;
               st_next.lane_n = 2'h3;
               st_next.cnt    = '0;
               st_next.state  = asc_pkg::ASC_TURN;
            end else begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end
         end
         asc_pkg::ASC_WRITE: begin
            // Hold everything for the longest write-end minimum
            // Output enable stays high, so the memory never fights the data
            if (st_reg.cnt == cyc(`ASC_WR_CYC - 1)) begin // RL9 RL12 RL13 RL22
               // Strobe and select rise together; data stays driven
               st_next.we_n   = 1'b1; // RL15 RL16
               st_next.sel_n  = 1'b1;
               st_next.state  = asc_pkg::ASC_WEND;
            end else begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end
         end
         asc_pkg::ASC_WEND: begin
            // Data drive and lanes released one cycle after the end edge; address holds
            // Hold time is zero; the extra cycle absorbs pin skew
            st_next.doe    = 2'h0; // RL11
            st_next.lane_n = 2'h3;
            st_next.ready  = 1'b1;
            st_next.state  = asc_pkg::ASC_IDLE;
         end
         asc_pkg::ASC_TURN: begin
            // Let the memory release the bus before the next access
            // Trade-off: one idle cycle per read buys a clean hand-over
            if (st_reg.cnt == cyc(`ASC_TURN_CYC - 1)) begin // RL7 RL3
               st_next.ready = 1'b1;
               st_next.state = asc_pkg::ASC_IDLE;
            end else begin
               st_next.cnt = st_reg.cnt + 1'b1;
            end
         end
         default: begin
            // Unused codes fall back to a safe idle
            st_next.state = asc_pkg::ASC_IDLE;
         end
      endcase
   end

   // State register with idle pin levels at reset
   // Counter and data cleared so the power-up wait starts from zero
   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg        <= '0;
         st_reg.state  <= asc_pkg::ASC_POWERUP;
         st_reg.sel_n  <= 1'b1;
         st_reg.oe_n   <= 1'b1;
         st_reg.we_n   <= 1'b1;
         st_reg.lane_n <= 2'h3;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   // No logic between register and pin keeps the pin timing clean
   assign req_ready        = st_reg.ready;
   assign rsp_valid        = st_reg.rvalid;
   assign rsp_rdata        = st_reg.rdata;
   assign mem_addr         = st_reg.addr;
   assign mem_sel_n        = st_reg.sel_n;
   assign mem_oe_n         = st_reg.oe_n;
   assign mem_we_n         = st_reg.we_n;
   assign lower_lane_sel_n = st_reg.lane_n[0];
   assign upper_lane_sel_n = st_reg.lane_n[1];
   assign mem_data_o       = st_reg.dout;
   assign mem_data_oe      = st_reg.doe;
endmodule
`default_nettype wire

// >>> src/asc_sync.sv
// Three-stage synchroniser for the read data pins.
// Assumes the pins are asynchronous to clock; output changes only when
// stages two and three agree.
`default_nettype none
module asc_sync #(
   parameter int W = 16
) (
   input  wire logic   clock,
   input  wire logic   rst,
   asc_sync_if.src     sif
);
   // All state in one packed struct
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] clean;
   } asc_sync_s;

   asc_sync_s st_reg;  // Registered state
   asc_sync_s st_next; // Next state

   // Shift chain; first stage feeds only the second
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = sif.raw;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // Accept a bit only once stages two and three agree
      for (int i = 0; i < W; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.clean[i] = st_reg.s3[i];
         end
      end
   end

   // State register
   always_ff @(posedge clock) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sif.clean = st_reg.clean;
endmodule
`default_nettype wire
